// ---- rtl/gpx_port.sv ----
`timescale 1ns/10ps
`default_nettype none

module gpx_port
	import gpx_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              latch_wr,
	input  wire logic              dir_wr,
	input  wire logic              opt_wr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              sens_wr,
	input  wire gpx_pkg::gpx_sens_t sens_wdata,
	input  wire logic              vec_fetch,
	input  wire logic [7:0]        af_en,
	input  wire logic [7:0]        af_out_en,
	input  wire logic [7:0]        af_out,
	input  wire logic [7:0]        af_pp,
	input  wire logic [7:0]        pin_in,
	output logic [7:0]             rd_data,
	output logic [7:0]             port_data_latch,
	output logic [7:0]             dir,
	output logic [7:0]             opt,
	output gpx_pkg::gpx_sens_t     sens,
	output logic                   ext_irq,
	output logic [7:0]             af_in,
	output logic [7:0]             pin_out,
	output logic [7:0]             pin_oe
);
	import gpx_pkg::*;

	// --------------------------------------------------------------
	// Configuration registers.
	// --------------------------------------------------------------
	logic [7:0] latch_q;
	logic [7:0] dir_q;
	logic [7:0] opt_q;
	gpx_sens_t  sens_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			latch_q <= LATCH_RST;
			dir_q   <= DIR_RST;
			opt_q   <= OPT_RST;
			sens_q  <= SENS_RST;
		end else begin
			if (latch_wr) begin
				latch_q <= wr_data;
			end
			if (dir_wr) begin
				dir_q <= wr_data;
			end
			if (opt_wr) begin
				opt_q <= wr_data;
			end
			if (sens_wr) begin
				sens_q <= sens_wdata;
			end
		end
	end

	// --------------------------------------------------------------
	// Pin synchroniser.
	// --------------------------------------------------------------
	logic [7:0] pin_m_q;
	logic [7:0] pin_s_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_m_q <= SYNC_RST;
			pin_s_q <= SYNC_RST;
		end else begin
			pin_m_q <= pin_in;
			pin_s_q <= pin_m_q;
		end
	end

	// --------------------------------------------------------------
	// Drive selection.
	// --------------------------------------------------------------
	wire [7:0] af_drv;
	wire [7:0] drv_en;
	wire [7:0] drv_val;
	wire [7:0] drv_pp;
	wire [7:0] oe_d;
	wire [7:0] rd_d;
	wire [7:0] af_in_d;

	// A peripheral output takes the pin over whatever the port says.
	assign af_drv  = af_en & af_out_en;
	assign drv_en  = af_drv | (dir_q & ~af_en);
	assign drv_val = (af_drv & af_out) | (~af_drv & latch_q);
	// High side is allowed only in push-pull and never on true open-drain pads.
	assign drv_pp  = ((af_drv & af_pp) | (~af_drv & opt_q)) & ~TRUE_OD_MASK;
	// Low always drives; high drives only in push-pull, else the pin floats.
	assign oe_d    = drv_en & (~drv_val | drv_pp);
	// Reads see the real pin, or the peripheral output on a pin the peripheral drives.
	assign rd_d    = (af_drv & af_out) | (~af_drv & pin_s_q);
	// A peripheral input on an output pin sees the latch content.
	assign af_in_d = (dir_q & latch_q) | (~dir_q & pin_s_q);

	logic [7:0] pin_out_q;
	logic [7:0] pin_oe_q;
	logic [7:0] rd_q;
	logic [7:0] af_in_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out_q <= PIN_OUT_RST;
			pin_oe_q  <= PIN_OE_RST;
			rd_q      <= RD_RST;
			af_in_q   <= AF_IN_RST;
		end else begin
			pin_out_q <= drv_val & drv_pp & drv_en;
			pin_oe_q  <= oe_d;
			rd_q      <= rd_d;
			af_in_q   <= af_in_d;
		end
	end

	// --------------------------------------------------------------
	// External interrupt.
	// --------------------------------------------------------------
	wire [7:0] irq_sel;
	wire       any_sel;
	wire       grp_lvl;
	wire       rise_evt;
	wire       fall_evt;
	wire       set_evt;
	logic      grp_q;
	logic      irq_q;

	// Interrupt inputs are input pins with the option bit set.
	assign irq_sel  = ~dir_q & opt_q;
	assign any_sel  = |irq_sel;
	// Unselected pins read as one, so any selected low pin masks the rest.
	assign grp_lvl  = &(pin_s_q | ~irq_sel);
	assign rise_evt = grp_lvl & ~grp_q;
	assign fall_evt = ~grp_lvl & grp_q;
	assign set_evt  = any_sel & (
		(sens_q == SENS_FALL_LOW & ~grp_lvl) |
		(sens_q == SENS_RISE & rise_evt) |
		(sens_q == SENS_FALL & fall_evt) |
		(sens_q == SENS_BOTH & (rise_evt | fall_evt)));

	always_ff @(posedge clk) begin
		if (rst) begin
			grp_q <= GRP_RST;
			irq_q <= IRQ_RST;
		end else begin
			grp_q <= grp_lvl;
			// A new event wins over the clear in the same cycle.
			if (set_evt) begin
				irq_q <= 1'b1;
			end else if (vec_fetch | sens_wr) begin
				irq_q <= 1'b0;
			end
		end
	end

	assign rd_data         = rd_q;
	assign port_data_latch = latch_q;
	assign dir             = dir_q;
	assign opt             = opt_q;
	assign sens            = sens_q;
	assign ext_irq         = irq_q;
	assign af_in           = af_in_q;
	assign pin_out         = pin_out_q;
	assign pin_oe          = pin_oe_q;

	// --------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------
	property p_in_no_drive;
		@(posedge clk) disable iff (rst)
		1 |=> ((pin_oe_q & $past(~dir_q & ~af_drv)) == 8'h00);
	endproperty
	a_in_no_drive: assert property (p_in_no_drive)
		else $error("Input pin is driven.");

	property p_pp_high;
		@(posedge clk) disable iff (rst)
		1 |=> ((pin_oe_q & pin_out_q) ==
			$past(dir_q & ~af_en & opt_q & latch_q & ~TRUE_OD_MASK | af_drv & af_out & af_pp & ~TRUE_OD_MASK));
	endproperty
	a_pp_high: assert property (p_pp_high)
		else $error("Push-pull high drive wrong.");

	property p_od_float;
		@(posedge clk) disable iff (rst)
		1 |=> ((pin_oe_q & $past(dir_q & ~af_en & ~opt_q & latch_q)) == 8'h00);
	endproperty
	a_od_float: assert property (p_od_float)
		else $error("Open-drain high is driven.");

	property p_low_drive;
		@(posedge clk) disable iff (rst)
		1 |=> ((pin_oe_q & ~pin_out_q) == $past(drv_en & ~drv_val));
	endproperty
	a_low_drive: assert property (p_low_drive)
		else $error("Low drive wrong.");

	property p_true_od;
		@(posedge clk) disable iff (rst)
		((pin_out_q & TRUE_OD_MASK) == 8'h00);
	endproperty
	a_true_od: assert property (p_true_od)
		else $error("True open-drain pin driven high.");

	property p_rd_pin;
		@(posedge clk) disable iff (rst)
		($past(af_drv) == 8'h00) && !$past(rst, 3) |-> rd_q == $past(pin_in, 3);
	endproperty
	a_rd_pin: assert property (p_rd_pin)
		else $error("Read does not show pin level.");

	property p_af_rd;
		@(posedge clk) disable iff (rst)
		1 |=> ((rd_q & $past(af_drv)) == $past(af_out & af_drv));
	endproperty
	a_af_rd: assert property (p_af_rd)
		else $error("Read does not show peripheral output.");

	property p_af_dir;
		@(posedge clk) disable iff (rst)
		1 |=> ((pin_oe_q & $past(af_drv & ~af_out)) == $past(af_drv & ~af_out));
	endproperty
	a_af_dir: assert property (p_af_dir)
		else $error("Peripheral output not driven.");

	property p_vec_clear;
		@(posedge clk) disable iff (rst)
		vec_fetch && !set_evt |=> !irq_q;
	endproperty
	a_vec_clear: assert property (p_vec_clear)
		else $error("Vector fetch left request set.");

	property p_sens_discard;
		@(posedge clk) disable iff (rst)
		sens_wr && !set_evt |=> !irq_q;
	endproperty
	a_sens_discard: assert property (p_sens_discard)
		else $error("Sensitivity write kept request.");

	property p_irq_cause;
		@(posedge clk) disable iff (rst)
		$rose(irq_q) |-> $past(any_sel) && $past(set_evt);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("Request without event.");

	property p_irq_hold;
		@(posedge clk) disable iff (rst)
		irq_q && !vec_fetch && !sens_wr |=> irq_q;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("Request dropped without clear.");

	property p_blocked;
		@(posedge clk) disable iff (rst)
		((irq_sel & ~pin_s_q) != 8'h00) && (sens_q == SENS_RISE) |-> !set_evt;
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("Low pin did not mask group.");

	property p_out_quiet;
		@(posedge clk) disable iff (rst)
		((pin_out_q & ~pin_oe_q) == 8'h00);
	endproperty
	a_out_quiet: assert property (p_out_quiet)
		else $error("Output level shown on undriven pin.");

	property p_sync;
		@(posedge clk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> pin_s_q == $past(pin_in, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("Synchroniser output wrong.");

	property p_af_in;
		@(posedge clk) disable iff (rst)
		($past(dir_q) == 8'h00) && !$past(rst, 3) |-> af_in_q == $past(pin_in, 3);
	endproperty
	a_af_in: assert property (p_af_in)
		else $error("Peripheral input does not show pin level.");

	property p_latch_wr;
		@(posedge clk) disable iff (rst)
		latch_wr |=> latch_q == $past(wr_data);
	endproperty
	a_latch_wr: assert property (p_latch_wr)
		else $error("Latch write lost.");

	property p_sens_wr;
		@(posedge clk) disable iff (rst)
		sens_wr |=> sens_q == $past(sens_wdata);
	endproperty
	a_sens_wr: assert property (p_sens_wr)
		else $error("Sensitivity write lost.");

	property p_level_set;
		@(posedge clk) disable iff (rst)
		(sens_q == SENS_FALL_LOW) && any_sel && !grp_lvl |=> irq_q;
	endproperty
	a_level_set: assert property (p_level_set)
		else $error("Low level did not raise request.");

	c_irq_edge: cover property (@(posedge clk) disable iff (rst)
		sens_q == SENS_FALL && set_evt ##1 irq_q ##[1:4] vec_fetch ##1 !irq_q);
	c_od_low: cover property (@(posedge clk) disable iff (rst)
		dir_q[0] && !opt_q[0] && latch_q[0] ##2 !pin_in[0] ##3 !rd_q[0]);
	c_af_out: cover property (@(posedge clk) disable iff (rst)
		af_drv[1] && !dir_q[1] ##1 pin_oe_q[1]);
	c_sens_cancel: cover property (@(posedge clk) disable iff (rst)
		irq_q && sens_wr ##1 !irq_q);
	c_group_mask: cover property (@(posedge clk) disable iff (rst)
		(irq_sel == 8'h03) && !pin_s_q[1] && pin_s_q[0] ##[1:40] !pin_s_q[0]);

endmodule

`default_nettype wire

// ---- rtl/gpx_pkg.sv ----
package gpx_pkg;

	// --------------------------------------------------------------
	// Port geometry and reset values.
	// --------------------------------------------------------------
	localparam int         PIN_W       = 8;
	localparam logic [7:0] LATCH_RST   = 8'h00;
	localparam logic [7:0] DIR_RST     = 8'h00;
	localparam logic [7:0] OPT_RST     = 8'h00;
	localparam logic [7:0] PIN_OUT_RST = 8'h00;
	localparam logic [7:0] PIN_OE_RST  = 8'h00;
	localparam logic [7:0] RD_RST      = 8'h00;
	localparam logic [7:0] SYNC_RST    = 8'h00;
	localparam logic [7:0] AF_IN_RST   = 8'h00;
	localparam logic       GRP_RST     = 1'b1;
	localparam logic       IRQ_RST     = 1'b0;

	// Pins built as true open-drain pads: never driven high.
	localparam logic [7:0] TRUE_OD_MASK = 8'h00;

	// Direction and option bit meanings.
	localparam logic DIR_IN      = 1'b0;
	localparam logic DIR_OUT     = 1'b1;
	localparam logic OPT_FLOAT   = 1'b0;
	localparam logic OPT_IRQ     = 1'b1;
	localparam logic OPT_OD      = 1'b0;
	localparam logic OPT_PP      = 1'b1;

	// --------------------------------------------------------------
	// External interrupt sensitivity.
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		SENS_FALL_LOW,
		SENS_RISE,
		SENS_FALL,
		SENS_BOTH
	} gpx_sens_t;

	localparam gpx_sens_t SENS_RST = SENS_FALL_LOW;

endpackage

// ---- verif/gpx_pins.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------
// External pad circuitry with a pull-up on every pin.
// ----------------------------------------------------------
module gpx_pins (
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic [7:0]      lvl
);
	// A pin that nobody drives is pulled high by its resistor.
	assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import gpx_pkg::*;
	logic            clk, rst, latch_wr, dir_wr, opt_wr, sens_wr, vec_fetch, ext_irq;
	logic      [7:0] wr_data, af_en, af_out_en, af_out, af_pp, pin_in, rd_data;
	logic      [7:0] port_data_latch, dir, opt, af_in, pin_out, pin_oe, ext_en, ext_val;
	gpx_sens_t       sens_wdata, sens;
	int              n_errors, comparisons;
	int              cycles = 0;

	gpx_port dut (.clk(clk), .rst(rst), .latch_wr(latch_wr), .dir_wr(dir_wr),
		.opt_wr(opt_wr), .wr_data(wr_data), .sens_wr(sens_wr), .sens_wdata(sens_wdata),
		.vec_fetch(vec_fetch), .af_en(af_en), .af_out_en(af_out_en), .af_out(af_out),
		.af_pp(af_pp), .pin_in(pin_in), .rd_data(rd_data),
		.port_data_latch(port_data_latch), .dir(dir), .opt(opt), .sens(sens),
		.ext_irq(ext_irq), .af_in(af_in), .pin_out(pin_out), .pin_oe(pin_oe));
	gpx_pins pads (.pin_oe(pin_oe), .pin_out(pin_out), .ext_en(ext_en), .ext_val(ext_val),
		.lvl(pin_in));

	// ----------------------------------------------------------
	// Clock, timeout and access tasks.
	// ----------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Strobe kinds: 0 latch, 1 direction, 2 option, 3 sensitivity, 4 vector fetch.
	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk);
		wr_data <= d;
		sens_wdata <= gpx_sens_t'(d[1:0]);
		latch_wr <= (k == 0);
		dir_wr <= (k == 1);
		opt_wr <= (k == 2);
		sens_wr <= (k == 3);
		vec_fetch <= (k == 4);
		@(posedge clk);
		{latch_wr, dir_wr, opt_wr, sens_wr, vec_fetch} <= 5'h00;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic pads_set(input logic [7:0] en, input logic [7:0] v);
		@(posedge clk);
		ext_en <= en;
		ext_val <= v;
	endtask

	// ----------------------------------------------------------
	// Test sequence.
	// ----------------------------------------------------------
	initial begin
		{rst, latch_wr, dir_wr, opt_wr, sens_wr, vec_fetch} = 6'h20;
		{wr_data, af_en, af_out_en, af_out, af_pp} = 40'h0;
		sens_wdata = SENS_FALL_LOW;
		ext_en = 8'hff;
		ext_val = 8'h3c;
		n_errors = 0;
		comparisons = 0;
		cyc(11);
		@(posedge clk) rst <= 1'b0;
		cyc(1);
		chk("dir", DIR_RST, dir);
		chk("oe", 8'h00, pin_oe | opt | port_data_latch | {7'h0, ext_irq});
		$display("test reset done");

		wr(0, 8'ha5);
		cyc(5);
		chk("oe", 8'h00, pin_oe);
		chk("latch", 8'ha5, port_data_latch);
		chk("rd", 8'h3c, rd_data);
		$display("test input done");

		pads_set(8'h00, 8'h00);
		wr(2, 8'hff);
		wr(1, 8'h0f);
		cyc(5);
		chk("oe", 8'h0f, pin_oe);
		chk("rd", 8'hf5, rd_data);
		chk("dir", 8'h0f, dir);
		chk("opt", 8'hff, opt);
		$display("test push pull done");

		pads_set(8'h01, 8'h00);
		wr(2, 8'h00);
		wr(0, 8'ha5);
		cyc(5);
		chk("oe", 8'h0a, pin_oe);
		chk("rd", 8'hf4, rd_data);
		$display("test open drain done");

		pads_set(8'h00, 8'h00);
		@(posedge clk) {af_en, af_out_en, af_out, af_pp} <= 32'hc080_0080;
		cyc(5);
		chk("oe", 8'h80, pin_oe & 8'hc0);
		chk("rd", 8'h40, rd_data & 8'hc0);
		chk("af_in", 8'h40, af_in & 8'h40);
		chk("af_in", 8'h05, af_in & 8'h0f);
		@(posedge clk) af_out <= 8'h80;
		cyc(3);
		chk("out", 8'h80, pin_out & 8'h80);
		@(posedge clk) {af_en, af_out_en, af_out, af_pp} <= 32'h0;
		$display("test alternate done");

		wr(1, 8'h00);
		wr(2, 8'h01);
		for (int m = 0; m < 4; m++) begin
			wr(3, 8'(m));
			cyc(4);
			chk("sens", 8'(m), {6'h0, sens});
			pads_set(8'h01, 8'h00);
			cyc(6);
			chk("irq", {7'h0, m != 1}, {7'h0, ext_irq});
			if (m == 2) begin
				wr(4, 8'h00);
				cyc(2);
				chk("irq", 8'h00, {7'h0, ext_irq});
			end
			pads_set(8'h00, 8'h00);
			cyc(6);
			chk("irq", {7'h0, m != 2}, {7'h0, ext_irq});
			wr(3, 8'(m));
			cyc(2);
			chk("irq", 8'h00, {7'h0, ext_irq});
		end
		$display("test interrupt done");

		wr(2, 8'h03);
		pads_set(8'h02, 8'h00);
		cyc(6);
		wr(3, 8'(SENS_FALL));
		cyc(4);
		pads_set(8'h03, 8'h00);
		cyc(6);
		chk("irq", 8'h00, {7'h0, ext_irq});
		pads_set(8'h00, 8'h00);
		cyc(6);
		pads_set(8'h01, 8'h00);
		cyc(6);
		chk("irq", 8'h01, {7'h0, ext_irq});
		$display("test group done");
		conclude();
	end
endmodule

`default_nettype wire
